//--- hw/adc_ctl_pkg.sv
// shared constants and types for the conversion control block
package adc_ctl_pkg;
   // ==========================================================
   // timing
   localparam int unsigned CLK_NS = 8;
   localparam int unsigned PER10_NS = 100_000_000;
   localparam int unsigned PER50_NS = 20_000_000;
   localparam int unsigned PER60_NS = 16_666_667;
   localparam int unsigned PER120_NS = 8_333_333;
   localparam int unsigned PER10_CYC = PER10_NS / CLK_NS;
   localparam int unsigned PER50_CYC = PER50_NS / CLK_NS;
   localparam int unsigned PER60_CYC = PER60_NS / CLK_NS;
   localparam int unsigned PER120_CYC = PER120_NS / CLK_NS;
   localparam logic [2:0] SETTLE_PERIODS = 3'h4;
   localparam int unsigned PD_MIN_NS = 100;
   localparam logic [3:0] PD_CYC = 4'((PD_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam int unsigned GUARD_NS = 10_000;
   localparam logic [23:0] GUARD_CYC = 24'(GUARD_NS / CLK_NS);
   // ==========================================================
   // data path
   localparam int unsigned WORD_W = 24;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam logic [4:0] WORD_BITS = 5'h18;
   // ==========================================================
   // pin decodes
   localparam logic [1:0] RATE_10 = 2'h3;
   localparam logic [1:0] RATE_50 = 2'h2;
   localparam logic [1:0] RATE_60 = 2'h1;
   localparam logic [1:0] RATE_120 = 2'h0;
   localparam logic [7:0] HZ_10 = 8'h0a;
   localparam logic [7:0] HZ_50 = 8'h32;
   localparam logic [7:0] HZ_60 = 8'h3c;
   localparam logic [7:0] HZ_120 = 8'h78;
   localparam logic [1:0] GSEL_1 = 2'h0;
   localparam logic [1:0] GSEL_8 = 2'h1;
   localparam logic [1:0] GSEL_64 = 2'h2;
   localparam logic [7:0] GAIN_1 = 8'h01;
   localparam logic [7:0] GAIN_8 = 8'h08;
   localparam logic [7:0] GAIN_64 = 8'h40;
   localparam logic [7:0] GAIN_128 = 8'h80;
   // ==========================================================
   // register map
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_RESULT = 12'h008;
   localparam logic [11:0] REG_COUNT = 12'h00c;
   localparam int unsigned CTRL_RESTART_BIT = 0;
   // ==========================================================
   // types
   typedef struct packed {
      logic [1:0] rate;
      logic [1:0] gain;
      logic pair;
   } pin_cfg_t;
   typedef enum logic [3:0] {
      ST_SETTLE = 4'b0001,
      ST_WAIT = 4'b0010,
      ST_READY = 4'b0100,
      ST_PD = 4'b1000
   } phase_t;
   typedef struct packed {
      logic [17:0] zero;
      logic oe;
      logic dout;
      pin_cfg_t cfg;
      logic [2:0] settle;
      phase_t state;
   } status_t;
endpackage : adc_ctl_pkg

//--- hw/sample_fifo.sv
// result buffer between filter output and output register
`timescale 1ns/100ps
`default_nettype none
module sample_fifo #(
   parameter int unsigned W = 24,
   parameter int unsigned DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] cnt;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic rdy;
      logic empty;
      logic [W-1:0] dout;
   } fifo_st_t;

   fifo_st_t s;
   fifo_st_t n;
   logic [W-1:0] mem [DEPTH];
   logic push;
   logic pop;

   // ==========================================================
   // pointers and flags
   always_comb begin
      push = in_valid & s.rdy & ~flush;
      pop = out_ready & ~s.empty & ~flush;
      n = s;
      if (flush) begin
         n.cnt = '0;
         n.wr = '0;
         n.rd = '0;
      end else begin
         if (push) begin
            n.wr = s.wr + 1'b1;
         end
         if (pop) begin
            n.rd = s.rd + 1'b1;
            n.dout = mem[s.rd];
         end
         n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
      end
      n.empty = (n.cnt == '0);
      n.rdy = (n.cnt != (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.rdy <= 1'b1;
         s.empty <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // storage carries no reset; contents are only read once written
   always_ff @(posedge clk) begin
      if (push) begin
         mem[s.wr] <= in_data;
      end
   end

   assign in_ready = s.rdy;
   assign out_valid = ~s.empty;
   assign out_data = s.dout;
endmodule : sample_fifo
`default_nettype wire

//--- hw/conv_ctrl.sv
// pin-configured conversion sequencer, serial output and apb registers
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - rate pins 11,10,01,00 select 10, 50, 60, 120 Hz periods.
// - rate pin change resets filter, forces output high, restarts at new rate.
// - first result after restart waits four periods, then one per period.
// - every completed conversion is loaded, settling or not.
// - output stays high while settling after a rate change; host reads first.
// - gain pins 00,01,10,11 select gain 1, 8, 64, 128.
// - gain pin change resets filter, output high, full settling before result.
// - pair select low picks first input pair, high picks second.
// - channel change holds output high until settling ends.
// - at 10, 60, 120 Hz notches sit at the rate and multiples.
// - at 50 Hz an extra notch is placed at 60 Hz.
// - each result is a 24-bit word.
// - output low on new result, high once read or before next update.
// - bits change on serial clock falling edge, host samples on rising.
// - results are offset binary; the result register holds the raw filter word, sign bit not inverted.
// - power-down high tristates output and resets everything; 100 ns minimum. The result and count registers keep their values.
module conv_ctrl
   import adc_ctl_pkg::*;
#(
   parameter logic [23:0] P10_CYC = 24'(PER10_CYC),
   parameter logic [23:0] P50_CYC = 24'(PER50_CYC),
   parameter logic [23:0] P60_CYC = 24'(PER60_CYC),
   parameter logic [23:0] P120_CYC = 24'(PER120_CYC)
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rate_sel_lo,
   input wire logic rate_sel_hi,
   input wire logic gain_sel_lo,
   input wire logic gain_sel_hi,
   input wire logic input_pair_sel,
   input wire logic powerdown_reset_in,
   input wire logic sclk,
   output logic serial_out,
   output logic serial_out_oe,
   input wire logic sample_valid,
   input wire logic [23:0] sample_data,
   output logic sample_ready,
   output logic [7:0] gain_value,
   output logic pair_sel,
   output logic [7:0] notch_base_hz,
   output logic notch_extra_60,
   output logic filter_reset
);
   typedef struct packed {
      phase_t state;
      pin_cfg_t cfg_s1;
      pin_cfg_t cfg_s2;
      pin_cfg_t cfg_prev;
      logic pd_s1;
      logic pd_s2;
      logic sck_s1;
      logic sck_s2;
      logic sck_s3;
      logic [3:0] pd_cnt;
      logic [23:0] per_len;
      logic [23:0] per_cnt;
      logic [2:0] settle_cnt;
      logic restart;
      logic pop;
      logic load_pend;
      logic [23:0] shift;
      logic [4:0] bit_cnt;
      logic dout;
      logic oe;
      logic [23:0] result;
      logic [15:0] conv_cnt;
      logic [7:0] gain;
      logic pair;
      logic [7:0] notch_hz;
      logic notch60;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic soft_rst;
   } conv_st_t;

   conv_st_t st;
   conv_st_t n;
   pin_cfg_t pins;
   status_t sts;
   logic [23:0] plen;
   logic sck_fall;
   logic sck_rise;
   logic chg;
   logic go;
   logic per_end;
   logic take;
   logic shift_now;
   logic fifo_valid;
   logic [23:0] fifo_data;

   assign pins = '{rate: {rate_sel_hi, rate_sel_lo},
                   gain: {gain_sel_hi, gain_sel_lo},
                   pair: input_pair_sel};

   // ==========================================================
   // filter output buffer
   sample_fifo #(
      .W(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(pclk),
      .rst_n(presetn),
      .flush(st.restart | (st.state == ST_PD)),
      .in_valid(sample_valid),
      .in_ready(sample_ready),
      .in_data(sample_data),
      .out_valid(fifo_valid),
      .out_ready(st.pop),
      .out_data(fifo_data)
   );

   // ==========================================================
   // sequencer
   always_comb begin
      n = st;
      n.restart = 1'b0;
      n.pop = 1'b0;
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      n.soft_rst = 1'b0;
      // stage two of each synchroniser feeds logic; sclk and the pins also use stage three
      n.cfg_s1 = pins;
      n.cfg_s2 = st.cfg_s1;
      n.cfg_prev = st.cfg_s2;
      n.pd_s1 = powerdown_reset_in;
      n.pd_s2 = st.pd_s1;
      n.sck_s1 = sclk;
      n.sck_s2 = st.sck_s1;
      n.sck_s3 = st.sck_s2;
      sck_fall = st.sck_s3 & ~st.sck_s2;
      sck_rise = ~st.sck_s3 & st.sck_s2;
      chg = (st.cfg_s2 != st.cfg_prev) | st.soft_rst;
      go = ~st.pd_s2 & (chg | (st.state == ST_PD));
      per_end = (st.per_cnt == 24'h000001);
      take = st.load_pend & ~st.pd_s2 & ~go;
      n.load_pend = st.pop & ~go & ~st.pd_s2; // fifo data lags its pop
      shift_now = (st.state == ST_READY) & sck_fall &
                  (st.bit_cnt != WORD_BITS) & (st.per_cnt != GUARD_CYC);
      case (st.cfg_s2.rate)
         RATE_10: begin
            plen = P10_CYC;
            n.notch_hz = HZ_10;
         end
         RATE_50: begin
            plen = P50_CYC;
            n.notch_hz = HZ_50;
         end
         RATE_60: begin
            plen = P60_CYC;
            n.notch_hz = HZ_60;
         end
         default: begin
            plen = P120_CYC;
            n.notch_hz = HZ_120;
         end
      endcase
      n.notch60 = (st.cfg_s2.rate == RATE_50);
      case (st.cfg_s2.gain)
         GSEL_1: n.gain = GAIN_1;
         GSEL_8: n.gain = GAIN_8;
         GSEL_64: n.gain = GAIN_64;
         default: n.gain = GAIN_128;
      endcase
      n.pair = st.cfg_s2.pair;
      if (st.pd_s2) begin
         // tristate at once, full reset only once the pulse is long enough
         n.oe = 1'b0;
         n.dout = 1'b1;
         if (st.pd_cnt != PD_CYC) begin
            n.pd_cnt = st.pd_cnt + 4'h1;
         end else begin
            n.state = ST_PD;
         end
      end else begin
         n.pd_cnt = 4'h0;
         n.oe = 1'b1;
         if (go) begin
            // host is expected to have finished any read by now
            n.restart = 1'b1;
            n.state = ST_SETTLE;
            n.dout = 1'b1;
            n.per_len = plen;
            n.per_cnt = plen;
            n.settle_cnt = 3'h0;
            n.bit_cnt = 5'h00;
         end else begin
            n.per_cnt = per_end ? st.per_len : st.per_cnt - 24'h000001;
            if (take) begin
               // serial interface restarts with every new word
               n.shift = {~fifo_data[23], fifo_data[22:0]};
               n.result = fifo_data;
               n.conv_cnt = st.conv_cnt + 16'h0001;
               n.state = ST_READY;
               n.dout = 1'b0;
               n.bit_cnt = 5'h00;
            end else begin
               case (st.state)
                  ST_SETTLE: begin
                     if (per_end) begin
                        if (st.settle_cnt == SETTLE_PERIODS - 3'h1) begin
                           n.settle_cnt = SETTLE_PERIODS;
                           if (fifo_valid) begin
                              n.pop = 1'b1;
                           end else begin
                              n.state = ST_WAIT;
                           end
                        end else begin
                           n.settle_cnt = st.settle_cnt + 3'h1;
                        end
                     end
                  end
                  ST_WAIT: begin
                     if (per_end && fifo_valid) begin
                        n.pop = 1'b1;
                     end
                  end
                  ST_READY: begin
                     if (st.per_cnt == GUARD_CYC) begin
                        n.dout = 1'b1;
                        n.state = ST_WAIT;
                     end else if (shift_now) begin
                        n.dout = st.shift[23];
                        n.shift = {st.shift[22:0], 1'b0};
                        n.bit_cnt = st.bit_cnt + 5'h01;
                     end else if (sck_rise && st.bit_cnt == WORD_BITS) begin
                        n.dout = 1'b1;
                        n.state = ST_WAIT;
                     end
                  end
                  default: n.state = ST_PD;
               endcase
            end
         end
      end
      // register access
      sts = '{zero: '0, oe: st.oe, dout: st.dout, cfg: st.cfg_prev,
              settle: st.settle_cnt, state: st.state};
      if (psel && !penable) begin
         n.pready = 1'b1;
         case (paddr)
            REG_CTRL: n.prdata = 32'h00000000;
            REG_STATUS: n.prdata = sts;
            REG_RESULT: n.prdata = {8'h00, st.result};
            REG_COUNT: n.prdata = {16'h0000, st.conv_cnt};
            default: begin
               n.prdata = 32'h00000000;
               n.pslverr = 1'b1;
            end
         endcase
      end
      if (psel && penable && st.pready && pwrite && paddr == REG_CTRL) begin
         n.soft_rst = pwdata[CTRL_RESTART_BIT];
      end
   end

   // power-down state first, so the first low level triggers a restart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.state <= ST_PD;
         st.dout <= 1'b1;
      end else begin
         st <= n;
      end
   end

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign serial_out = st.dout;
   assign serial_out_oe = st.oe;
   assign gain_value = st.gain;
   assign pair_sel = st.pair;
   assign notch_base_hz = st.notch_hz;
   assign notch_extra_60 = st.notch60;
   assign filter_reset = st.restart;

   // ==========================================================
   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence restart_seq;
      st.restart;
   endsequence
   sequence load_seq;
      take;
   endsequence
   sequence shift_seq;
      shift_now && !st.pd_s2 && !go;
   endsequence

   restart_state_a: assert property (
      restart_seq |-> serial_out && st.state == ST_SETTLE &&
         st.settle_cnt == 3'h0 ##1 st.per_cnt == st.per_len - 24'h000001 ||
         st.restart || st.pd_s2)
      else $error("restart did not clear sequencer");
   reload_a: assert property (
      restart_seq |-> st.per_cnt == st.per_len)
      else $error("period counter not reloaded");
   rate_map_a: assert property (
      st.restart && st.cfg_prev.rate == RATE_10 |-> st.per_len == P10_CYC)
      else $error("10 Hz period wrong");
   rate_fast_a: assert property (
      st.restart && st.cfg_prev.rate == RATE_120 |-> st.per_len == P120_CYC)
      else $error("120 Hz period wrong");
   settle_high_a: assert property (
      st.state == ST_SETTLE |-> serial_out)
      else $error("output low while settling");
   settle_exit_a: assert property (
      st.state == ST_READY && $past(st.state) == ST_SETTLE |->
         $past(st.settle_cnt) == SETTLE_PERIODS)
      else $error("left settling early");
   gain_map_a: assert property (
      st.cfg_prev.gain == GSEL_8 |-> gain_value == GAIN_8)
      else $error("gain decode wrong");
   pair_map_a: assert property (
      $rose(st.cfg_s2.pair) |=> pair_sel)
      else $error("pair select not followed");
   notch_50_a: assert property (
      st.cfg_prev.rate == RATE_50 |-> notch_extra_60 && notch_base_hz == HZ_50)
      else $error("50 Hz notch setup wrong");
   notch_10_a: assert property (
      st.cfg_prev.rate == RATE_10 |-> !notch_extra_60 && notch_base_hz == HZ_10)
      else $error("10 Hz notch setup wrong");
   ready_low_a: assert property (
      load_seq |=> !serial_out ##1 (!serial_out || st.state != ST_READY ||
         $past(shift_now)))
      else $error("ready not signalled");
   load_count_a: assert property (
      load_seq |=> st.conv_cnt == $past(st.conv_cnt) + 16'h0001)
      else $error("result load not counted");
   offset_bin_a: assert property (
      load_seq |=> st.shift[23] == ~$past(fifo_data[23]))
      else $error("sign bit not offset");
   shift_out_a: assert property (
      shift_seq |=> serial_out == $past(st.shift[23]))
      else $error("wrong bit shifted out");
   pin_restart_a: assert property (
      st.cfg_s2 != st.cfg_prev && !st.pd_s2 |=> st.restart)
      else $error("pin change missed");
   pd_tristate_a: assert property (
      st.pd_s2 |=> !serial_out_oe)
      else $error("output driven in power-down");
endmodule : conv_ctrl
`default_nettype wire

//--- dv/host_reader.sv
// host side model: reads result words over the two-wire link
`timescale 1ns/100ps
`default_nettype none
module host_reader (
   input wire logic serial_out,
   input wire logic serial_out_oe,
   output logic sclk
);
   logic line;
   // ==========================================================
   // line level
   // a released line has no pull: show the inverse, never the last bit
   assign line = serial_out_oe ? serial_out : ~serial_out;
   // ==========================================================
   // word read
   // clock idles high between frames; half period 62.5 ns
   initial sclk = 1'b1;
   task automatic read_word(output logic [23:0] w, output logic ok);
      int n;
      ok = 1'b0;
      w = '0;
      for (n = 0; n < 6000 && line !== 1'b0; n++) #8;
      if (line === 1'b0) begin
         ok = 1'b1;
         for (n = 0; n < 24; n++) begin
            #62.5 sclk = 1'b0;
            #62.5 sclk = 1'b1;
            w = {w[22:0], line};
         end
      end
   endtask : read_word
endmodule : host_reader
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench for the conversion control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import adc_ctl_pkg::*;
   // periods exceed guard time plus one word read; index is rate pin code
   localparam int PER [4] = '{1800, 1900, 2000, 2100};
   localparam logic [7:0] HZT [4] = '{HZ_120, HZ_60, HZ_50, HZ_10};
   localparam logic [7:0] GNT [4] = '{GAIN_1, GAIN_8, GAIN_64, GAIN_128};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   pin_cfg_t cfg = '0;
   logic pd_in = 1'b0;
   logic sclk;
   logic serial_out;
   logic serial_out_oe;
   logic sample_valid = 1'b0;
   logic [23:0] sample_data = '0;
   logic sample_ready;
   logic [7:0] gain_value;
   logic [7:0] notch_base_hz;
   logic pair_sel;
   logic notch_extra_60;
   logic filter_reset;
   int bad_count = 0;
   int samples_checked = 0;
   int pulses = 0;
   int cyc = 0;
   int t_rst = 0;
   conv_ctrl #(.P10_CYC(24'(PER[3])), .P50_CYC(24'(PER[2])),
      .P60_CYC(24'(PER[1])), .P120_CYC(24'(PER[0]))) conv_ctrl_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rate_sel_lo(cfg.rate[0]),
      .rate_sel_hi(cfg.rate[1]), .gain_sel_lo(cfg.gain[0]),
      .gain_sel_hi(cfg.gain[1]), .input_pair_sel(cfg.pair),
      .powerdown_reset_in(pd_in), .sclk(sclk), .serial_out(serial_out),
      .serial_out_oe(serial_out_oe), .sample_valid(sample_valid),
      .sample_data(sample_data), .sample_ready(sample_ready),
      .gain_value(gain_value), .pair_sel(pair_sel),
      .notch_base_hz(notch_base_hz), .notch_extra_60(notch_extra_60),
      .filter_reset(filter_reset));
   host_reader host_reader_inst (.serial_out(serial_out),
      .serial_out_oe(serial_out_oe), .sclk(sclk));
   initial begin
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (filter_reset === 1'b1) begin
         pulses <= pulses + 1;
         t_rst <= cyc;
      end
   end
   // ==========================================================
   // tasks
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // pready is taken at the rising edge that ends the access cycle
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk("pready", 1, 0);
   endtask : apb
   task automatic set_cfg(pin_cfg_t v);
      @(posedge pclk);
      cfg <= v;
      repeat (8) @(posedge pclk);
   endtask : set_cfg
   task automatic push(logic [23:0] d);
      int n;
      @(posedge pclk);
      sample_valid <= 1'b1;
      sample_data <= d;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (sample_ready !== 1'b1 && n < 20000);
      sample_valid <= 1'b0;
      if (n >= 20000) chk("sample_ready", 1, 0);
   endtask : push
   task automatic wait_lvl(logic lvl, int lim, output int t);
      int n;
      n = 0;
      while (serial_out !== lvl && n < lim) begin
         @(negedge pclk);
         n++;
      end
      t = cyc;
      if (n >= lim) chk("line level", lvl, ~lvl);
   endtask : wait_lvl
   task automatic read_chk(logic [23:0] raw);
      logic [23:0] w;
      logic ok;
      int t;
      host_reader_inst.read_word(w, ok);
      chk("link word", {8'h0, raw ^ 24'h800000}, {8'h0, w});
      wait_lvl(1'b1, 50, t);
   endtask : read_chk
   task automatic settle_rd(logic [23:0] raw);
      int t;
      int p;
      p = 4 * PER[cfg.rate];
      push(raw);
      wait_lvl(1'b0, p + 100, t);
      chk("settle", 1, 32'(t - t_rst >= p && t - t_rst <= p + 8));
      read_chk(raw);
   endtask : settle_rd
   // ==========================================================
   // tests
   initial begin
      logic [31:0] d;
      logic e;
      int p0;
      int c0;
      int t1;
      int t2;
      pin_cfg_t c;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      apb(0, REG_CTRL, 0, d, e);
      chk("ctrl", 0, d);
      apb(0, 12'h010, 0, d, e);
      chk("unmapped err", 1, {31'h0, e});
      chk("unmapped data", 0, d);
      apb(1, REG_STATUS, 32'hffffffff, d, e);
      chk("ro err", 0, {31'h0, e});
      apb(0, REG_STATUS, 0, d, e);
      chk("status", 32'h00003001, d & 32'hffffff8f);
      apb(0, REG_RESULT, 0, d, e);
      chk("result", 0, d);
      apb(0, REG_COUNT, 0, d, e);
      chk("count", 0, d);
      for (int r = 3; r >= 0; r--) begin
         p0 = pulses;
         set_cfg('{rate: 2'(r), gain: 2'(r), pair: r[0]});
         chk("notch", {24'h0, HZT[r]}, {24'h0, notch_base_hz});
         chk("extra", 32'(r == 2), {31'h0, notch_extra_60});
         chk("gain", {24'h0, GNT[r]}, {24'h0, gain_value});
         chk("pair", 32'(r % 2), {31'h0, pair_sel});
         chk("restart", p0 + 1, pulses);
         chk("line high", 1, {31'h0, serial_out});
      end
      settle_rd(24'h000001);
      push(24'h7fffff);
      push(24'h800000);
      wait_lvl(1'b0, 2000, t1);
      read_chk(24'h7fffff);
      wait_lvl(1'b0, 2000, t2);
      chk("period", PER[0], t2 - t1);
      push(24'h0000ff);
      wait_lvl(1'b1, PER[0] + 20, t1);
      wait_lvl(1'b0, GUARD_CYC + 50, t1);
      read_chk(24'h0000ff);
      apb(0, REG_RESULT, 0, d, e);
      chk("result", 32'h0000ff, d);
      apb(0, REG_COUNT, 0, d, e);
      chk("count", 4, d & 32'hffff);
      c = cfg;
      c.gain = 2'h3;
      set_cfg(c);
      settle_rd(24'h123456);
      c.pair = 1'b1;
      set_cfg(c);
      settle_rd(24'hfedcba);
      p0 = pulses;
      apb(1, REG_CTRL, 32'h1, d, e);
      repeat (4) @(posedge pclk);
      chk("soft restart", p0 + 1, pulses);
      apb(0, REG_COUNT, 0, d, e);
      c0 = d[15:0];
      for (int i = 0; i < 16; i++) push(24'(i * 24'h010101));
      @(negedge pclk);
      chk("fifo full", 0, {31'h0, sample_ready});
      wait_lvl(1'b0, 4 * PER[0] + 100, t1);
      read_chk(24'h000000);
      chk("fifo space", 1, {31'h0, sample_ready});
      repeat (16 * PER[0]) @(posedge pclk);
      apb(0, REG_COUNT, 0, d, e);
      chk("count", c0 + 16, d & 32'hffff);
      p0 = pulses;
      pd_in <= 1'b1;
      repeat (5) @(negedge pclk);
      chk("oe off", 0, {31'h0, serial_out_oe});
      repeat (20) @(posedge pclk);
      pd_in <= 1'b0;
      repeat (8) @(negedge pclk);
      chk("pd restart", 1, 32'(pulses > p0));
      chk("oe on", 1, {31'h0, serial_out_oe});
      chk("line high", 1, {31'h0, serial_out});
      settle_rd(24'habcdef);
      tally_and_finish();
   end
   initial begin
      repeat (90000) @(posedge pclk);
      bad_count++;
      $display("ERROR watchdog expected end seen hang");
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
